//--- src/fsc_params.svh
// Opcodes, bit positions, reset values and timing counts of the flash status block
`ifndef FSC_PARAMS_SVH
`define FSC_PARAMS_SVH

`define FSC_OP_READ_STATUS 8'h05
`define FSC_OP_WRITE_ENABLE 8'h06
`define FSC_OP_WRITE_DISABLE 8'h04
`define FSC_OP_WRITE_STATUS 8'h01
`define FSC_OP_PAGE_PROGRAM 8'h02
`define FSC_OP_SECTOR_ERASE 8'h20
`define FSC_OP_BLOCK_ERASE 8'hd8
`define FSC_OP_CHIP_ERASE 8'h60

`define FSC_ST_BUSY 0
`define FSC_ST_WEL 1
`define FSC_ST_BP_LSB 2
`define FSC_ST_BP_MSB 5
`define FSC_ST_QE 6
`define FSC_ST_LOCK 7
`define FSC_CFG_TB 3
`define FSC_CFG_DC 7
`define FSC_BYTE_MSB 7

`define FSC_BP_RESET 4'h0
`define FSC_BIT_RESET 1'b0
`define FSC_BYTE_RESET 8'h00
`define FSC_ADDR_RESET 24'h000000
`define FSC_SYNC_RESET 4'hf

`define FSC_DUMMY_LONG 4'h8
`define FSC_DUMMY_SHORT 4'h6

`define FSC_CNT_OPCODE 3'h1
`define FSC_CNT_STATUS_ONLY 3'h2
`define FSC_CNT_WITH_CONFIG 3'h3
`define FSC_CNT_ADDRESS 3'h4
`define FSC_CNT_PROGRAM 3'h5
`define FSC_CNT_MAX 3'h7
`define FSC_BIT_LAST 3'h7
`define FSC_BIT_FIRST 3'h0

`define FSC_CLK_PERIOD_NS 4
`define FSC_WRITE_STATUS_CMD_TIME_NS 1000
`define FSC_WRITE_STATUS_CMD_CYCLES ((`FSC_WRITE_STATUS_CMD_TIME_NS + `FSC_CLK_PERIOD_NS - 1) / `FSC_CLK_PERIOD_NS)
`define FSC_TIMER_ZERO 12'h000
`define FSC_TIMER_ONE 12'h001

`endif

//--- src/fsc_pkg.sv
// Types shared by the flash status block
package fsc_pkg;
  typedef logic [7:0] fsc_byte_t;
  typedef enum logic [1:0] {CMD_IDLE, CMD_OPCODE, CMD_READ_STATUS, CMD_COLLECT} fsc_cmd_e;
endpackage

//--- src/fsc_frame_if.sv
// Serial frame events passed from the receiver to the command core
`timescale 1ns/1ps
`default_nettype none
interface fsc_frame_if;
  logic active;
  logic frame_start;
  logic frame_end;
  logic sclk_fall;
  logic byte_valid;
  logic [7:0] byte_data;
  logic [2:0] byte_count;
  logic [2:0] bit_count;
  modport rx (output active, frame_start, frame_end, sclk_fall, byte_valid, byte_data,
    byte_count, bit_count);
  modport core (input active, frame_start, frame_end, sclk_fall, byte_valid, byte_data,
    byte_count, bit_count);
endinterface
`default_nettype wire

//--- src/fsc_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module fsc_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= RESET_VALUE;
      q <= RESET_VALUE;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

//--- src/fsc_frame_rx.sv
// Serial frame receiver: finds clock edges and assembles bytes within a select frame
`timescale 1ns/1ps
`default_nettype none
module fsc_frame_rx
  import fsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cs_n_s,
  input wire logic sclk_s,
  input wire logic si_s,
  fsc_frame_if.rx frm
);
  `include "fsc_params.svh"

  logic sclk_d_reg;
  logic cs_n_d_reg;
  fsc_byte_t shift_reg;
  logic rise_now;
  logic start_now;

  assign rise_now = ~cs_n_s & ~sclk_d_reg & sclk_s;
  assign start_now = cs_n_d_reg & ~cs_n_s;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sclk_d_reg <= `FSC_BIT_RESET;
      cs_n_d_reg <= 1'b1;
      frm.active <= `FSC_BIT_RESET;
      frm.frame_start <= `FSC_BIT_RESET;
      frm.frame_end <= `FSC_BIT_RESET;
      frm.sclk_fall <= `FSC_BIT_RESET;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_n_d_reg <= cs_n_s;
      frm.active <= ~cs_n_s;
      frm.frame_start <= start_now;
      frm.frame_end <= ~cs_n_d_reg & cs_n_s;
      frm.sclk_fall <= ~cs_n_s & sclk_d_reg & ~sclk_s;
    end
  end

  // Counts are cleared at the start of a frame so they still hold at its end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_reg <= `FSC_BYTE_RESET;
      frm.bit_count <= `FSC_BIT_FIRST;
      frm.byte_count <= `FSC_BIT_FIRST;
      frm.byte_data <= `FSC_BYTE_RESET;
      frm.byte_valid <= `FSC_BIT_RESET;
    end else begin
      frm.byte_valid <= `FSC_BIT_RESET;
      if (start_now) begin
        frm.bit_count <= `FSC_BIT_FIRST;
        frm.byte_count <= `FSC_BIT_FIRST;
      end else if (rise_now) begin
        shift_reg <= {shift_reg[6:0], si_s};
        frm.bit_count <= frm.bit_count + 3'h1;
        if (frm.bit_count == `FSC_BIT_LAST) begin
          frm.byte_data <= {shift_reg[6:0], si_s};
          frm.byte_valid <= 1'b1;
          if (frm.byte_count != `FSC_CNT_MAX) begin
            frm.byte_count <= frm.byte_count + 3'h1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- src/fsc_top.sv
// Status and configuration register logic of the serial flash with its command handling
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Status-read opcode after select falls shifts status out on serial output.
// - Status read accepted any time, even busy, and repeats while clocked.
// - Upper data lines are ignored during status read.
// - Bit 0 reads 1 while program, erase or status write runs.
// - Program, erase, status write accepted only while write-enable latch is 1.
// - Program or erase on protected area ignored and clears write-enable latch.
// - Bits 5..2 are protect level, changed only by status write.
// - Chip erase runs only when all protect-level bits are zero.
// - Protect-level bits default to zero, memory unprotected.
// - Quad bit defaults 0; at 1 protect pin ignored, lock mode off.
// - Hardware lock when status-lock bit is 1 and protect pin low.
// - Hardware lock rejects status write, freezing lock and protect bits.
// - Config bit 3 one-time top/bottom select, default 0, set by status write.
// - Config bit 7 selects 8 dummy clocks at 1, 6 at 0.
// - Reserved config bits are written as don't care, read unreliable.
// - Write-enable command sets the write-enable latch.
// - Status write never touches busy or write-enable latch from its data.
// - Busy during status-write cycle; at end busy clears and latch clears.
module fsc_top
  import fsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic write_protect_pin,
  input wire logic array_addr_protected,
  input wire logic array_op_done,
  output logic so,
  output logic so_oe_n,
  output logic array_op_start,
  output logic [7:0] array_op_code,
  output logic [23:0] array_op_addr,
  output logic [3:0] protect_level,
  output logic protect_from_bottom,
  output logic quad_io_enable,
  output logic [3:0] dummy_cycle_count
);
  `include "fsc_params.svh"

  fsc_frame_if frm ();
  logic cs_n_s;
  logic sclk_s;
  logic si_s;
  logic wp_s;

  fsc_sync #(.WIDTH(4), .RESET_VALUE(`FSC_SYNC_RESET)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({cs_n, sclk, si, write_protect_pin}),
    .q({cs_n_s, sclk_s, si_s, wp_s})
  );

  fsc_frame_rx u_rx (
    .clk_sys(clk_sys),
    .rst(rst),
    .cs_n_s(cs_n_s),
    .sclk_s(sclk_s),
    .si_s(si_s),
    .frm(frm)
  );

  fsc_cmd_e state_reg;
  fsc_byte_t opcode_reg;
  fsc_byte_t status_data_reg;
  fsc_byte_t config_data_reg;
  logic [23:0] addr_reg;
  logic [11:0] write_status_cmd_timer_reg;
  logic array_busy_reg;
  logic wel_reg;
  logic [3:0] bp_reg;
  logic qe_reg;
  logic lock_reg;
  logic tb_reg;
  logic dc_reg;
  fsc_byte_t out_shift_reg;
  logic [2:0] out_ptr_reg;
  logic so_reg;
  logic so_oe_n_reg;
  logic op_start_reg;
  fsc_byte_t op_code_reg;
  logic [3:0] dummy_reg;

  logic busy;
  logic hw_lock;
  fsc_byte_t flash_status_byte;
  logic end_ok;
  logic cnt_one;
  logic is_pe_op;
  logic pe_len_ok;
  logic write_enable_cmd_go;
  logic wrdi_go;
  logic write_status_cmd_go;
  logic pe_cmd;
  logic pe_refused;
  logic pe_go;
  logic write_status_cmd_done;
  logic array_done;

  assign busy = (write_status_cmd_timer_reg != `FSC_TIMER_ZERO) || array_busy_reg;
  // Quad mode drops the pin function, so lock cannot engage there
  assign hw_lock = lock_reg & ~wp_s & ~qe_reg;
  assign flash_status_byte = {lock_reg, qe_reg, bp_reg, wel_reg, busy};

  // Commands act only when select rises exactly on a byte boundary
  assign end_ok = frm.frame_end && (state_reg == CMD_COLLECT) && (frm.bit_count == `FSC_BIT_FIRST);
  assign cnt_one = frm.byte_count == `FSC_CNT_OPCODE;
  assign is_pe_op = (opcode_reg == `FSC_OP_PAGE_PROGRAM) || (opcode_reg == `FSC_OP_SECTOR_ERASE) ||
    (opcode_reg == `FSC_OP_BLOCK_ERASE) || (opcode_reg == `FSC_OP_CHIP_ERASE);
  always_comb begin
    pe_len_ok = 1'b0;
    if (opcode_reg == `FSC_OP_CHIP_ERASE) begin
      pe_len_ok = cnt_one;
    end else if (opcode_reg == `FSC_OP_PAGE_PROGRAM) begin
      pe_len_ok = frm.byte_count >= `FSC_CNT_PROGRAM;
    end else begin
      pe_len_ok = frm.byte_count == `FSC_CNT_ADDRESS;
    end
  end

  assign write_enable_cmd_go = end_ok && cnt_one && (opcode_reg == `FSC_OP_WRITE_ENABLE) && !busy;
  assign wrdi_go = end_ok && cnt_one && (opcode_reg == `FSC_OP_WRITE_DISABLE) && !busy;
  assign write_status_cmd_go = end_ok && (opcode_reg == `FSC_OP_WRITE_STATUS) && wel_reg && !busy &&
    !hw_lock && ((frm.byte_count == `FSC_CNT_STATUS_ONLY) ||
    (frm.byte_count == `FSC_CNT_WITH_CONFIG));
  assign pe_cmd = end_ok && is_pe_op && pe_len_ok && wel_reg && !busy;
  assign pe_refused = pe_cmd && ((opcode_reg == `FSC_OP_CHIP_ERASE) ?
    (bp_reg != `FSC_BP_RESET) : array_addr_protected);
  assign pe_go = pe_cmd && !pe_refused;
  assign write_status_cmd_done = write_status_cmd_timer_reg == `FSC_TIMER_ONE;
  assign array_done = array_busy_reg && array_op_done;

  // Status read is taken regardless of busy
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= CMD_IDLE;
      opcode_reg <= `FSC_BYTE_RESET;
    end else if (frm.frame_start) begin
      state_reg <= CMD_OPCODE;
    end else if (frm.frame_end || !frm.active) begin
      state_reg <= CMD_IDLE;
    end else if (frm.byte_valid && (state_reg == CMD_OPCODE)) begin
      opcode_reg <= frm.byte_data;
      state_reg <= (frm.byte_data == `FSC_OP_READ_STATUS) ? CMD_READ_STATUS : CMD_COLLECT;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_reg <= `FSC_ADDR_RESET;
      status_data_reg <= `FSC_BYTE_RESET;
      config_data_reg <= `FSC_BYTE_RESET;
    end else if (frm.byte_valid && (state_reg == CMD_COLLECT)) begin
      if (frm.byte_count <= `FSC_CNT_ADDRESS) begin
        addr_reg <= {addr_reg[15:0], frm.byte_data};
      end
      if (frm.byte_count == `FSC_CNT_STATUS_ONLY) begin
        status_data_reg <= frm.byte_data;
      end
      if (frm.byte_count == `FSC_CNT_WITH_CONFIG) begin
        config_data_reg <= frm.byte_data;
      end
    end
  end

  // Program or erase refusals and completions clear the latch; set and clear never meet since set needs idle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wel_reg <= `FSC_BIT_RESET;
    end else if (write_enable_cmd_go) begin
      wel_reg <= 1'b1;
    end else if (wrdi_go || pe_refused || write_status_cmd_done || array_done) begin
      wel_reg <= `FSC_BIT_RESET;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      write_status_cmd_timer_reg <= `FSC_TIMER_ZERO;
    end else if (write_status_cmd_go) begin
      write_status_cmd_timer_reg <= 12'(`FSC_WRITE_STATUS_CMD_CYCLES);
    end else if (write_status_cmd_timer_reg != `FSC_TIMER_ZERO) begin
      write_status_cmd_timer_reg <= write_status_cmd_timer_reg - 12'h001;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      array_busy_reg <= `FSC_BIT_RESET;
      op_start_reg <= `FSC_BIT_RESET;
      op_code_reg <= `FSC_BYTE_RESET;
    end else begin
      op_start_reg <= pe_go;
      if (pe_go) begin
        array_busy_reg <= 1'b1;
        op_code_reg <= opcode_reg;
      end else if (array_op_done) begin
        array_busy_reg <= `FSC_BIT_RESET;
      end
    end
  end

  // Non-volatile bits come up at factory defaults; data never reaches busy or latch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bp_reg <= `FSC_BP_RESET;
      qe_reg <= `FSC_BIT_RESET;
      lock_reg <= `FSC_BIT_RESET;
    end else if (write_status_cmd_go) begin
      bp_reg <= status_data_reg[`FSC_ST_BP_MSB:`FSC_ST_BP_LSB];
      qe_reg <= status_data_reg[`FSC_ST_QE];
      lock_reg <= status_data_reg[`FSC_ST_LOCK];
    end
  end

  // Reserved config bits are dropped; top/bottom can only be set, never cleared
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tb_reg <= `FSC_BIT_RESET;
      dc_reg <= `FSC_BIT_RESET;
      dummy_reg <= `FSC_DUMMY_SHORT;
    end else begin
      dummy_reg <= dc_reg ? `FSC_DUMMY_LONG : `FSC_DUMMY_SHORT;
      if (write_status_cmd_go && (frm.byte_count == `FSC_CNT_WITH_CONFIG)) begin
        tb_reg <= tb_reg | config_data_reg[`FSC_CFG_TB];
        dc_reg <= config_data_reg[`FSC_CFG_DC];
      end
    end
  end

  // Each new byte snapshots the live status so busy changes show on the next byte
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_shift_reg <= `FSC_BYTE_RESET;
      out_ptr_reg <= `FSC_BIT_FIRST;
      so_reg <= `FSC_BIT_RESET;
      so_oe_n_reg <= 1'b1;
    end else if (frm.frame_end || !frm.active || (state_reg != CMD_READ_STATUS)) begin
      out_ptr_reg <= `FSC_BIT_FIRST;
      so_reg <= `FSC_BIT_RESET;
      so_oe_n_reg <= 1'b1;
    end else if (frm.sclk_fall) begin
      so_oe_n_reg <= `FSC_BIT_RESET;
      out_ptr_reg <= out_ptr_reg + 3'h1;
      if (out_ptr_reg == `FSC_BIT_FIRST) begin
        so_reg <= flash_status_byte[`FSC_BYTE_MSB];
        out_shift_reg <= {flash_status_byte[6:0], 1'b0};
      end else begin
        so_reg <= out_shift_reg[`FSC_BYTE_MSB];
        out_shift_reg <= {out_shift_reg[6:0], 1'b0};
      end
    end
  end
  // Upper data lines have no port at all, so their levels cannot disturb a status read

  assign so = so_reg;
  assign so_oe_n = so_oe_n_reg;
  assign array_op_start = op_start_reg;
  assign array_op_code = op_code_reg;
  assign array_op_addr = addr_reg;
  assign protect_level = bp_reg;
  assign protect_from_bottom = tb_reg;
  assign quad_io_enable = qe_reg;
  assign dummy_cycle_count = dummy_reg;

  sequence seq_write_status_cmd_rise;
    (write_status_cmd_timer_reg == `FSC_TIMER_ZERO) ##1 (write_status_cmd_timer_reg != `FSC_TIMER_ZERO);
  endsequence
  sequence seq_write_status_cmd_finish;
    write_status_cmd_done ##1 (write_status_cmd_timer_reg == `FSC_TIMER_ZERO);
  endsequence

  AST_BUSY_BIT: assert property (@(posedge clk_sys) disable iff (rst)
    write_status_cmd_go || pe_go |=> flash_status_byte[`FSC_ST_BUSY])
    else $error("busy bit not raised by an accepted write cycle");
  AST_WRITE_STATUS_CMD_NEEDS_WEL: assert property (@(posedge clk_sys) disable iff (rst)
    seq_write_status_cmd_rise |-> $past(wel_reg))
    else $error("status write started without write enable");
  AST_REFUSE_CLEARS_WEL: assert property (@(posedge clk_sys) disable iff (rst)
    pe_refused |=> !wel_reg && !op_start_reg)
    else $error("refused program or erase left latch or started");
  AST_CHIP_ERASE_BP: assert property (@(posedge clk_sys) disable iff (rst)
    op_start_reg && (op_code_reg == `FSC_OP_CHIP_ERASE) |-> $past(bp_reg) == `FSC_BP_RESET)
    else $error("chip erase started with protection set");
  AST_LOCK_FREEZE: assert property (@(posedge clk_sys) disable iff (rst)
    hw_lock |=> $stable(bp_reg) && $stable(lock_reg) && (write_status_cmd_timer_reg == `FSC_TIMER_ZERO ||
    $past(write_status_cmd_timer_reg) != `FSC_TIMER_ZERO))
    else $error("status changed under hardware lock");
  AST_QUAD_NO_LOCK: assert property (@(posedge clk_sys) disable iff (rst)
    end_ok && qe_reg && wel_reg && !busy && (opcode_reg == `FSC_OP_WRITE_STATUS) &&
    ((frm.byte_count == `FSC_CNT_STATUS_ONLY) || (frm.byte_count == `FSC_CNT_WITH_CONFIG))
    |=> (write_status_cmd_timer_reg != `FSC_TIMER_ZERO))
    else $error("status write refused in quad mode");
  AST_TB_ONE_TIME: assert property (@(posedge clk_sys) disable iff (rst)
    $past(tb_reg) |-> tb_reg)
    else $error("top/bottom select was cleared");
  AST_DUMMY_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
    ##1 dummy_cycle_count == ($past(dc_reg) ? `FSC_DUMMY_LONG : `FSC_DUMMY_SHORT))
    else $error("dummy count does not match select bit");
  AST_WRITE_STATUS_CMD_END: assert property (@(posedge clk_sys) disable iff (rst)
    seq_write_status_cmd_finish |-> !wel_reg && !flash_status_byte[`FSC_ST_BUSY] || array_busy_reg)
    else $error("status write end left latch or busy set");
  AST_SO_SHIFT: assert property (@(posedge clk_sys) disable iff (rst)
    frm.sclk_fall && (state_reg == CMD_READ_STATUS) && frm.active && !frm.frame_end &&
    (out_ptr_reg != `FSC_BIT_FIRST) |=> so_reg == $past(out_shift_reg[`FSC_BYTE_MSB]) &&
    !so_oe_n_reg)
    else $error("status bit not shifted out in order");
endmodule
`default_nettype wire

//--- dv/fsc_host_model.sv
// Host controller model: drives select, link clock and data in, captures status bytes
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"
module fsc_host_model
  import fsc_pkg::*;
(
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire logic so
);
  localparam real HALF_NS = 62.5;

  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b0;
  end

  // One link clock cycle in mode 0: data set while low, status bit taken at the rise
  // Non-blocking drives avoid a race where a pin edge lands on a system clock edge
  task automatic tick(input logic bit_in, output logic bit_out);
    si <= bit_in;
    #(HALF_NS);
    sclk <= 1'b1;
    bit_out = so;
    #(HALF_NS);
    sclk <= 1'b0;
  endtask

  // Whole frame: send bytes, clock nrx bytes back, then extra loose bits
  task automatic frame(input fsc_byte_t tx[$], input int nrx, input int extra,
                       output fsc_byte_t rx[$]);
    fsc_byte_t v;
    logic b;
    rx = {};
    v = 8'h00;
    cs_n <= 1'b0;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        tick(tx[i][k], b);
      end
    end
    for (int n = 0; n < nrx; n++) begin
      // Data in is don't care while reading, so it toggles instead of holding a level
      for (int k = 0; k < 8; k++) begin
        tick(~si, b);
        v = {v[6:0], b};
      end
      rx.push_back(v);
    end
    for (int k = 0; k < extra; k++) begin
      tick(~si, b);
    end
    #(HALF_NS);
    cs_n <= 1'b1;
    si <= ~si;
    // Gap lets the synchronisers see select high before the next frame
    #(4 * HALF_NS);
  endtask

  // Poll busy first and only then look at the latch
  task automatic wait_idle(output fsc_byte_t st);
    fsc_byte_t rx[$];
    st = 8'hff;
    for (int n = 0; n < 40; n++) begin
      frame({`FSC_OP_READ_STATUS}, 1, 0, rx);
      st = rx[0];
      if (st[`FSC_ST_BUSY] === 1'b0) break;
    end
  endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the flash status and configuration block
`timescale 1ns/1ps
`default_nettype none
`include "fsc_params.svh"
module testbench
  import fsc_pkg::*;
();
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cs_n, sclk, si, so, so_oe_n;
  logic write_protect_pin = 1'b1;
  logic array_addr_protected = 1'b0;
  logic array_op_done = 1'b0;
  logic array_op_start, protect_from_bottom, quad_io_enable;
  logic [7:0] array_op_code;
  logic [23:0] array_op_addr;
  logic [3:0] protect_level, dummy_cycle_count;
  int err_total = 0;
  int check_count = 0;
  int start_cnt = 0;
  logic [7:0] seen_code;
  logic [23:0] seen_addr;

  always #2 clk_sys = ~clk_sys;

  fsc_top dut_u (.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .sclk(sclk), .si(si),
    .write_protect_pin(write_protect_pin), .array_addr_protected(array_addr_protected),
    .array_op_done(array_op_done), .so(so), .so_oe_n(so_oe_n),
    .array_op_start(array_op_start), .array_op_code(array_op_code),
    .array_op_addr(array_op_addr), .protect_level(protect_level),
    .protect_from_bottom(protect_from_bottom), .quad_io_enable(quad_io_enable),
    .dummy_cycle_count(dummy_cycle_count));

  // A released output shows the inverse, so a missing enable corrupts the read
  fsc_host_model host_u (.cs_n(cs_n), .sclk(sclk), .si(si), .so(so_oe_n ? ~so : so));

  always @(posedge clk_sys) begin
    if (array_op_start === 1'b1) begin
      start_cnt <= start_cnt + 1;
      seen_code <= array_op_code;
      seen_addr <= array_op_addr;
    end
  end

  task automatic chk_status(input fsc_byte_t got, input fsc_byte_t exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t ns: status got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_port(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t ns: port got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input fsc_byte_t q[$], input int extra);
    fsc_byte_t rx[$];
    host_u.frame(q, 0, extra, rx);
  endtask

  task automatic rd(output fsc_byte_t st);
    fsc_byte_t rx[$];
    host_u.frame({`FSC_OP_READ_STATUS}, 1, 0, rx);
    st = rx[0];
  endtask

  // Reserved config bits are written but never read back
  task automatic write_status_cmd(input fsc_byte_t s, input fsc_byte_t c, output fsc_byte_t st);
    cmd({`FSC_OP_WRITE_ENABLE}, 0);
    cmd({`FSC_OP_WRITE_STATUS, s, c}, 0);
    host_u.wait_idle(st);
  endtask

  task automatic t_reset;
    fsc_byte_t rx[$];
    host_u.frame({`FSC_OP_READ_STATUS}, 2, 0, rx);
    chk_status(rx[0], 8'h00);
    chk_status(rx[1], 8'h00);
    chk_port(protect_level, 4'h0);
    chk_port(protect_from_bottom, 1'b0);
    chk_port(quad_io_enable, 1'b0);
    chk_port(dummy_cycle_count, `FSC_DUMMY_SHORT);
    chk_port(so_oe_n, 1'b1);
    $display("Test reset done");
  endtask

  task automatic t_latch;
    fsc_byte_t st;
    cmd({`FSC_OP_WRITE_ENABLE}, 0);
    rd(st);
    chk_status(st, 8'h02);
    cmd({`FSC_OP_WRITE_DISABLE}, 0);
    rd(st);
    chk_status(st, 8'h00);
    // Select raised off a byte boundary must not set the latch
    cmd({`FSC_OP_WRITE_ENABLE}, 3);
    rd(st);
    chk_status(st, 8'h00);
    $display("Test latch done");
  endtask

  task automatic t_write_status;
    fsc_byte_t st;
    write_status_cmd(8'h3c, 8'hff, st);
    chk_status(st, 8'h3c);
    chk_port(protect_level, 4'hf);
    chk_port(protect_from_bottom, 1'b1);
    chk_port(dummy_cycle_count, `FSC_DUMMY_LONG);
    cmd({`FSC_OP_WRITE_STATUS, 8'h00, 8'h00}, 0);
    rd(st);
    chk_status(st, 8'h3c);
    cmd({`FSC_OP_WRITE_ENABLE}, 0);
    cmd({`FSC_OP_CHIP_ERASE}, 0);
    rd(st);
    chk_status(st, 8'h3c);
    chk_port(start_cnt, 0);
    write_status_cmd(8'h00, 8'h00, st);
    chk_status(st, 8'h00);
    chk_port(protect_from_bottom, 1'b1);
    chk_port(dummy_cycle_count, `FSC_DUMMY_SHORT);
    $display("Test status write done");
  endtask

  task automatic t_array;
    fsc_byte_t ops[4] = '{`FSC_OP_PAGE_PROGRAM, `FSC_OP_SECTOR_ERASE,
                          `FSC_OP_BLOCK_ERASE, `FSC_OP_CHIP_ERASE};
    fsc_byte_t st;
    fsc_byte_t q[$];
    int n;
    for (int i = 0; i < 4; i++) begin
      n = start_cnt;
      q = {ops[i]};
      if (i < 3) q = {q, 8'h12, 8'h34, 8'(8'h50 + i)};
      if (i == 0) q.push_back(8'ha5);
      cmd({`FSC_OP_WRITE_ENABLE}, 0);
      cmd(q, 0);
      chk_port(start_cnt, n + 1);
      chk_port(seen_code, ops[i]);
      if (i < 3) chk_port(seen_addr, {16'h1234, 8'(8'h50 + i)});
      rd(st);
      chk_status(st, 8'h03);
      @(posedge clk_sys);
      array_op_done <= 1'b1;
      @(posedge clk_sys);
      array_op_done <= 1'b0;
      host_u.wait_idle(st);
      chk_status(st, 8'h00);
    end
    @(posedge clk_sys);
    array_addr_protected <= 1'b1;
    n = start_cnt;
    cmd({`FSC_OP_WRITE_ENABLE}, 0);
    cmd({`FSC_OP_SECTOR_ERASE, 8'h00, 8'h10, 8'h00}, 0);
    rd(st);
    chk_status(st, 8'h00);
    cmd({`FSC_OP_WRITE_ENABLE}, 0);
    cmd({`FSC_OP_PAGE_PROGRAM, 8'h00, 8'h10, 8'h00, 8'h5a}, 0);
    chk_port(start_cnt, n);
    rd(st);
    chk_status(st, 8'h00);
    @(posedge clk_sys);
    array_addr_protected <= 1'b0;
    $display("Test array commands done");
  endtask

  task automatic t_lock;
    fsc_byte_t st;
    write_status_cmd(8'h80, 8'h00, st);
    chk_status(st, 8'h80);
    @(posedge clk_sys);
    write_protect_pin <= 1'b0;
    cmd({`FSC_OP_WRITE_ENABLE}, 0);
    cmd({`FSC_OP_WRITE_STATUS, 8'h3c}, 0);
    host_u.wait_idle(st);
    chk_status(st & 8'hfc, 8'h80);
    chk_port(protect_level, 4'h0);
    @(posedge clk_sys);
    write_protect_pin <= 1'b1;
    write_status_cmd(8'hc0, 8'h00, st);
    chk_status(st, 8'hc0);
    chk_port(quad_io_enable, 1'b1);
    @(posedge clk_sys);
    write_protect_pin <= 1'b0;
    // Quad mode switches lock mode off, so the write goes through with the pin low
    write_status_cmd(8'h44, 8'h00, st);
    chk_status(st, 8'h44);
    chk_port(protect_level, 4'h1);
    $display("Test hardware lock done");
  endtask

  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_latch();
    t_write_status();
    t_array();
    t_lock();
    print_verdict();
  end

  // Whole run needs roughly 120 us of link traffic
  initial begin
    #300us;
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
